// ==== buck_fault_params.svh ====
// Constants for the buck fault supervisor
`ifndef BUCK_FAULT_PARAMS_SVH
`define BUCK_FAULT_PARAMS_SVH
`define CLK_MHZ              250
`define FILTER_US            20
`define FILTER_CYCLES        (`FILTER_US * `CLK_MHZ)
`define LIMIT_MS             10
`define LIMIT_CYCLES         (`LIMIT_MS * 1000 * `CLK_MHZ)
`define RETRY_MS             100
`define RETRY_CYCLES         (`RETRY_MS * 1000 * `CLK_MHZ)
`define GOOD_DELAY_MS        10
`define GOOD_DELAY_CYCLES    (`GOOD_DELAY_MS * 1000 * `CLK_MHZ)
`define RATE_MIN_KHZ         200
`define RATE_MAX_KHZ         1000
`define RATE_STEP_KHZ_X3     160
`define RATE_CODE_MAX        4'hF
`define COUNT_W              26
`endif

// ==== buck_fault_pkg.sv ====
// Types for the buck fault supervisor
package buck_fault_pkg;
   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_SOFT    = 3'b001,
      ST_DELAY   = 3'b010,
      ST_RUN     = 3'b011,
      ST_HOT     = 3'b100,
      ST_RETRY   = 3'b101
   } supervisor_state_t;
   typedef logic [25:0] cycle_count_t;
endpackage

// ==== buck_fault_supervisor.sv ====
// Fault supervisor for a synchronous buck termination regulator
// Function
// R1 - Over-voltage raises supply_ok_n; outputs stay enabled and loop keeps regulating.
// R2 - Over-voltage flag must hold 20 us before fault is declared.
// R3 - Over-voltage fault clears only below the falling level; supply_ok_n low.
// R4 - Under-voltage raises supply_ok_n while outputs stay enabled.
// R5 - Under-voltage flag must hold 20 us before fault is declared.
// R6 - Under-voltage fault clears only above the rising level; supply_ok_n low.
// R7 - Peak current limit starts cycle-by-cycle limiting and a 10 ms timer; here in run state only, peak flag ignored in soft start and delay.
// R8 - Current back to normal before timer expiry resumes with no fault action.
// R9 - Limit timer expiry disables output, raises supply_ok_n, retries after 100 ms.
// R10 - Over-temperature during limiting disables output and raises supply_ok_n.
// R11 - Short-circuit level disables output at once, no timer.
// R12 - After short-circuit shutdown wait 100 ms then soft start again.
// R13 - Over-temperature switches output off and raises supply_ok_n.
// R14 - After thermal shutdown wait for flag to clear, then 100 ms, then retry.
// R15 - Successful thermal retry drives supply_ok_n low again.
// R16 - Select at ground gives 1000 kHz, at internal supply gives 200 kHz.
// R17 - Sixteen select steps map 200 to 1000 kHz, higher level lower rate.
// R18 - After clean start with output regulated wait 10 ms before supply_ok_n low.
// R19 - Soft start on enable, power cycling and every fault retry.
// R20 - Select setting is latched on enable before soft start.
// R21 - Comparator flags pass synchronising stages before filtering or timing.
`timescale 1ns/1ps
`include "buck_fault_params.svh"
module buck_fault_supervisor
   import buck_fault_pkg::*;
#(
   parameter int LIMIT_CYCLES      = `LIMIT_CYCLES,
   parameter int RETRY_CYCLES      = `RETRY_CYCLES,
   parameter int GOOD_DELAY_CYCLES = `GOOD_DELAY_CYCLES,
   parameter int FILTER_CYCLES     = `FILTER_CYCLES
) (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RESET,
   // Enable and soft start handshake
   input  wire logic       ENABLE,
   input  wire logic       SOFT_START_DONE,
   // Comparator flags (asynchronous)
   input  wire logic       OVERVOLT_FLAG,
   input  wire logic       UNDERVOLT_FLAG,
   input  wire logic       PEAK_CURRENT_FLAG,
   input  wire logic       SHORT_CURRENT_FLAG,
   input  wire logic       OVERTEMP_FLAG,
   // Frequency select code, 0 is ground, 15 is internal supply
   input  wire logic [3:0] SWITCH_RATE_SELECT,
   // Converter control
   output logic            OUTPUT_ENABLE,
   output logic            SOFT_START,
   output logic            CURRENT_LIMITING,
   output logic [9:0]      SWITCH_RATE_KHZ,
   // Power good, open drain, active low
   output logic            SUPPLY_OK_N_OUT,
   output logic            SUPPLY_OK_N_OE
);

   // ************************************************************
   // Synchronisers
   // ************************************************************
   logic ov_s;
   logic uv_s;
   logic pk_s;
   logic sc_s;
   logic ot_s;
   logic en_s;
   logic [3:0] sel_s;
   logic [3:0] sel_m;

   flag_sync u_ov (.CLK(CLK), .RESET(RESET), .flag_in(OVERVOLT_FLAG), .flag_out(ov_s)); // R21
   flag_sync u_uv (.CLK(CLK), .RESET(RESET), .flag_in(UNDERVOLT_FLAG), .flag_out(uv_s)); // R21
   flag_sync u_pk (.CLK(CLK), .RESET(RESET), .flag_in(PEAK_CURRENT_FLAG), .flag_out(pk_s));
   flag_sync u_sc (.CLK(CLK), .RESET(RESET), .flag_in(SHORT_CURRENT_FLAG), .flag_out(sc_s));
   flag_sync u_ot (.CLK(CLK), .RESET(RESET), .flag_in(OVERTEMP_FLAG), .flag_out(ot_s));
   flag_sync u_en (.CLK(CLK), .RESET(RESET), .flag_in(ENABLE), .flag_out(en_s));

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sel
         flag_sync u_sel (
            .CLK      (CLK),
            .RESET    (RESET),
            .flag_in  (SWITCH_RATE_SELECT[gi]),
            .flag_out (sel_s[gi])
         );
      end
   endgenerate

   // Select bits cross one by one; a code counts after two equal samples
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sel_m <= 4'h0;
      end else begin
         sel_m <= sel_s;
      end
   end
   wire sel_steady = (sel_m == sel_s); // R20

   // ************************************************************
   // Voltage fault filters
   // ************************************************************
   cycle_count_t ov_cnt;
   cycle_count_t uv_cnt;
   logic         ov_fault;
   logic         uv_fault;
   wire          ov_qual = (ov_cnt == cycle_count_t'(FILTER_CYCLES - 1)); // R2
   wire          uv_qual = (uv_cnt == cycle_count_t'(FILTER_CYCLES - 1)); // R5

   always_ff @(posedge CLK) begin
      if (RESET || !ov_s) begin
         ov_cnt <= '0;
      end else if (!ov_qual) begin
         ov_cnt <= ov_cnt + 26'h0000001;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET || !uv_s) begin
         uv_cnt <= '0;
      end else if (!uv_qual) begin
         uv_cnt <= uv_cnt + 26'h0000001;
      end
   end

   // Flags stay set until the comparator releases past its hysteresis level
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ov_fault <= 1'b0;
         uv_fault <= 1'b0;
      end else begin
         ov_fault <= ov_s && (ov_fault || ov_qual); // R2 R3
         uv_fault <= uv_s && (uv_fault || uv_qual); // R5 R6
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   supervisor_state_t state;
   supervisor_state_t next_state;
   cycle_count_t      timer;
   logic              good;
   logic [3:0]        sel_latch;

   wire limit_expired = (timer == cycle_count_t'(LIMIT_CYCLES - 1));
   wire retry_expired = (timer == cycle_count_t'(RETRY_CYCLES - 1));
   wire delay_expired = (timer == cycle_count_t'(GOOD_DELAY_CYCLES - 1));
   wire limit_trip    = pk_s && limit_expired;
   wire powered       = (state == ST_SOFT) || (state == ST_DELAY) || (state == ST_RUN);
   wire trip_hot      = powered && ot_s; // R10 R13
   wire trip_short    = powered && sc_s; // R11
   wire trip_limit    = (state == ST_RUN) && limit_trip; // R9

   always_comb begin
      next_state = state;
      unique case (state)
         ST_OFF:   next_state = (en_s && sel_steady) ? ST_SOFT : ST_OFF; // R19 R20
         ST_SOFT:  next_state = SOFT_START_DONE ? ST_DELAY : ST_SOFT;
         ST_DELAY: next_state = delay_expired ? ST_RUN : ST_DELAY; // R18
         ST_RUN:   next_state = ST_RUN;
         ST_HOT:   next_state = ot_s ? ST_HOT : ST_RETRY; // R14
         ST_RETRY: next_state = retry_expired ? ST_SOFT : ST_RETRY; // R12 R19
         default:  next_state = ST_OFF;
      endcase
      if (trip_hot) begin
         next_state = ST_HOT; // R10 R13
      end else if (trip_short || trip_limit) begin
         next_state = ST_RETRY; // R9 R11
      end
      if (!en_s) begin
         next_state = ST_OFF;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Shared timer; in run state it times the current limit only while limiting
   always_ff @(posedge CLK) begin
      if (RESET || next_state != state) begin
         timer <= '0;
      end else if (state == ST_RUN && !pk_s) begin
         timer <= '0; // R8
      end else if (state != ST_OFF && state != ST_HOT && state != ST_SOFT) begin
         timer <= timer + 26'h0000001; // R7
      end
   end

   // Select is taken while leaving off state
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sel_latch <= 4'h0;
      end else if (state == ST_OFF && en_s && sel_steady) begin
         sel_latch <= sel_m; // R20
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Rate table in kHz, indexed by the latched select code
   logic [9:0] rate_lut [16];
   assign rate_lut[0]  = 10'h3E8; // R16
   assign rate_lut[1]  = 10'h3B3; // R17
   assign rate_lut[2]  = 10'h37D; // R17
   assign rate_lut[3]  = 10'h348; // R17
   assign rate_lut[4]  = 10'h313; // R17
   assign rate_lut[5]  = 10'h2DD; // R17
   assign rate_lut[6]  = 10'h2A8; // R17
   assign rate_lut[7]  = 10'h273; // R17
   assign rate_lut[8]  = 10'h23D; // R17
   assign rate_lut[9]  = 10'h208; // R17
   assign rate_lut[10] = 10'h1D2; // R17
   assign rate_lut[11] = 10'h19D; // R17
   assign rate_lut[12] = 10'h168; // R17
   assign rate_lut[13] = 10'h133; // R17
   assign rate_lut[14] = 10'h0FD; // R17
   assign rate_lut[15] = 10'h0C8; // R16
   wire [9:0] next_rate = rate_lut[sel_latch]; // R17
   wire       next_good = (state == ST_RUN) && !ov_fault && !uv_fault && !trip_hot &&
                          !trip_short && !trip_limit; // R13

   always_ff @(posedge CLK) begin
      if (RESET) begin
         OUTPUT_ENABLE    <= 1'b0;
         SOFT_START       <= 1'b0;
         CURRENT_LIMITING <= 1'b0;
         SWITCH_RATE_KHZ  <= 10'h3E8;
         good             <= 1'b0;
      end else begin
         OUTPUT_ENABLE    <= powered && !trip_hot && !trip_short && !trip_limit; // R1 R4
         SOFT_START       <= (next_state == ST_SOFT); // R19
         CURRENT_LIMITING <= (state == ST_RUN) && pk_s; // R7
         SWITCH_RATE_KHZ  <= next_rate; // R16 R17
         good             <= next_good; // R1 R3 R4 R6 R15
      end
   end

   assign SUPPLY_OK_N_OUT = 1'b0;
   assign SUPPLY_OK_N_OE  = good;

   // ************************************************************
   // Assertions
   // ************************************************************
   ov_filter_a: assert property (@(posedge CLK) disable iff (RESET) // R2
      $rose(ov_fault) |-> $past(ov_cnt) == cycle_count_t'(FILTER_CYCLES - 1))
      else $error("over-voltage declared before filter time");
   uv_filter_a: assert property (@(posedge CLK) disable iff (RESET) // R5
      $rose(uv_fault) |-> $past(uv_cnt) == cycle_count_t'(FILTER_CYCLES - 1))
      else $error("under-voltage declared before filter time");
   ov_good_a: assert property (@(posedge CLK) disable iff (RESET) // R1
      ov_fault && state == ST_RUN && !trip_hot && !trip_short && !trip_limit |=>
      !good && OUTPUT_ENABLE)
      else $error("over-voltage handling wrong");
   uv_good_a: assert property (@(posedge CLK) disable iff (RESET) // R4
      uv_fault && state == ST_RUN && !trip_hot && !trip_short && !trip_limit |=>
      !good && OUTPUT_ENABLE)
      else $error("under-voltage handling wrong");
   ov_clear_a: assert property (@(posedge CLK) disable iff (RESET) // R3
      ov_fault && !ov_s |=> !ov_fault)
      else $error("over-voltage fault did not clear");
   short_off_a: assert property (@(posedge CLK) disable iff (RESET) // R11
      trip_short && !trip_hot && en_s |=> !OUTPUT_ENABLE && state == ST_RETRY)
      else $error("short circuit did not disable output");
   hot_off_a: assert property (@(posedge CLK) disable iff (RESET) // R13
      trip_hot && en_s |=> !OUTPUT_ENABLE && !good && state == ST_HOT)
      else $error("over-temperature did not disable output");
   retry_soft_a: assert property (@(posedge CLK) disable iff (RESET) // R12
      state == ST_RETRY && retry_expired && en_s |=> state == ST_SOFT && SOFT_START)
      else $error("retry did not start soft start");
   delay_good_a: assert property (@(posedge CLK) disable iff (RESET) // R18
      $rose(good) |-> $past(state, 2) == ST_DELAY || $past(state, 2) == ST_RUN)
      else $error("power good before delay");
   rate_map_a: assert property (@(posedge CLK) disable iff (RESET) // R16
      $past(sel_latch) == 4'hF |-> SWITCH_RATE_KHZ == 10'h0C8)
      else $error("top select not 200 kHz");
   limit_ok_a: assert property (@(posedge CLK) disable iff (RESET) // R8
      state == ST_RUN && !pk_s |=> state != ST_RETRY || !en_s || $past(sc_s))
      else $error("fault action without limit");
   uv_clear_a: assert property (@(posedge CLK) disable iff (RESET) // R6
      uv_fault && !uv_s |=> !uv_fault)
      else $error("under-voltage fault did not clear");
   limit_trip_a: assert property (@(posedge CLK) disable iff (RESET) // R9
      trip_limit && !trip_hot && en_s |=> state == ST_RETRY && !OUTPUT_ENABLE && !good)
      else $error("limit timer expiry not handled");
   limit_flag_a: assert property (@(posedge CLK) disable iff (RESET) // R7
      CURRENT_LIMITING |-> $past(state) == ST_RUN && $past(pk_s))
      else $error("current limiting outside run");
   hot_hold_a: assert property (@(posedge CLK) disable iff (RESET) // R14
      state == ST_HOT && ot_s && en_s |=> state == ST_HOT)
      else $error("left thermal state while hot");
   off_retry_a: assert property (@(posedge CLK) disable iff (RESET) // R12
      state == ST_RETRY || state == ST_HOT |-> !OUTPUT_ENABLE)
      else $error("output on while waiting to retry");
   good_run_a: assert property (@(posedge CLK) disable iff (RESET) // R15
      good |-> $past(state) == ST_RUN)
      else $error("power good outside run");
   rate_low_a: assert property (@(posedge CLK) disable iff (RESET) // R16
      $past(sel_latch) == 4'h0 |-> SWITCH_RATE_KHZ == 10'h3E8)
      else $error("ground select not 1000 kHz");
   sel_hold_a: assert property (@(posedge CLK) disable iff (RESET) // R20
      state != ST_OFF |=> $stable(sel_latch))
      else $error("select changed after enable");
   soft_flag_a: assert property (@(posedge CLK) disable iff (RESET) // R19
      SOFT_START |-> state == ST_SOFT)
      else $error("soft start flag outside soft start");

endmodule // buck_fault_supervisor

// ==== buck_fault_supervisor_tb_top.sv ====
// Self-checking testbench for the buck fault supervisor
`timescale 1ns/1ps
module buck_fault_supervisor_tb_top;
   import buck_fault_pkg::*;
   localparam int LIM = 20;
   localparam int RTY = 40;
   localparam int GD  = 30;
   localparam logic [159:0] RATES = {10'h0C8, 10'h0FD, 10'h133, 10'h168, 10'h19D, 10'h1D2,
      10'h208, 10'h23D, 10'h273, 10'h2A8, 10'h2DD, 10'h313, 10'h348, 10'h37D, 10'h3B3, 10'h3E8};
   // ***************************************
   // Signals
   // ***************************************
   logic       clk, reset, enable, done;
   logic       ov, uv, peak, shrt, hot;
   logic [3:0] sel;
   logic       oe, ss, cl, pin_out, pin_oe, pin;
   logic [9:0] rate;
   int         num_errors, total_checks, cycles;
   buck_fault_supervisor #(.LIMIT_CYCLES(LIM), .RETRY_CYCLES(RTY),
      .GOOD_DELAY_CYCLES(GD), .FILTER_CYCLES(8)) dut (
      .CLK(clk), .RESET(reset), .ENABLE(enable), .SOFT_START_DONE(done),
      .OVERVOLT_FLAG(ov), .UNDERVOLT_FLAG(uv), .PEAK_CURRENT_FLAG(peak),
      .SHORT_CURRENT_FLAG(shrt), .OVERTEMP_FLAG(hot),
      .SWITCH_RATE_SELECT(sel), .OUTPUT_ENABLE(oe), .SOFT_START(ss),
      .CURRENT_LIMITING(cl), .SWITCH_RATE_KHZ(rate),
      .SUPPLY_OK_N_OUT(pin_out), .SUPPLY_OK_N_OE(pin_oe));
   host_monitor host (.drive_level(pin_out), .drive_enable(pin_oe),
      .supply_ok_n(pin));
   // ***************************************
   // Clock, timeout and helpers
   // ***************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return oe;
         1: return ss;
         2: return cl;
         default: return pin;
      endcase
   endfunction
   task automatic check_bit(input logic a, input logic e, input string m);
      total_checks++;
      if (a !== e) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic check_rate(input logic [9:0] a, input logic [9:0] e);
      total_checks++;
      if (a !== e) begin
         num_errors++;
         $display("[ERR] %0t rate %0d want %0d", $time, a, e);
      end
   endtask
   task automatic wait_on(input int w, input logic v, input int lim);
      int n;
      for (n = 0; n < lim && sig(w) !== v; n++) tick(1);
      check_bit(sig(w), v, "wait expired");
   endtask
   task automatic finish_start();
      int n;
      done = 1'b1;
      wait_on(1, 1'b0, 4);
      done = 1'b0;
      for (n = 0; n < GD + 10 && pin !== 1'b0; n++) tick(1);
      check_bit(n >= GD - 1 && n <= GD + 4, 1'b1, "good delay");
   endtask
   // ***************************************
   // Scenarios
   // ***************************************
   task automatic t_rate();
      for (int c = 0; c < 16; c++) begin
         enable = 1'b0;
         sel = 4'(c);
         tick(3);
         enable = 1'b1;
         tick(8);
         sel = ~4'(c);
         tick(8);
         check_rate(rate, RATES[c * 10 +: 10]);
      end
      $display("test rate done");
   endtask
   task automatic t_start();
      enable = 1'b0;
      sel = 4'h5;
      tick(8);
      enable = 1'b1;
      wait_on(1, 1'b1, 10);
      check_bit(pin, 1'b1, "pin low in soft start");
      finish_start();
      check_bit(oe, 1'b1, "output off");
      check_rate(rate, 10'h2DD);
      $display("test start done");
   endtask
   task automatic set_volt(input int w, input logic v);
      if (w == 0) ov = v;
      else uv = v;
   endtask
   task automatic t_volt(input int w);
      set_volt(w, 1'b1);
      tick(4);
      set_volt(w, 1'b0);
      tick(12);
      check_bit(pin, 1'b0, "short glitch flagged");
      set_volt(w, 1'b1);
      wait_on(3, 1'b1, 16);
      check_bit(oe, 1'b1, "output dropped");
      set_volt(w, 1'b0);
      wait_on(3, 1'b0, 10);
      $display("test volt %0d done", w);
   endtask
   task automatic t_limit();
      peak = 1'b1;
      wait_on(2, 1'b1, 8);
      tick(8);
      peak = 1'b0;
      wait_on(2, 1'b0, 8);
      check_bit(oe, 1'b1, "output off");
      check_bit(pin, 1'b0, "pin raised");
      peak = 1'b1;
      wait_on(0, 1'b0, LIM + 12);
      check_bit(pin, 1'b1, "pin low");
      peak = 1'b0;
      wait_on(1, 1'b1, RTY + 8);
      finish_start();
      $display("test limit done");
   endtask
   task automatic t_short();
      shrt = 1'b1;
      wait_on(0, 1'b0, 6);
      shrt = 1'b0;
      tick(RTY - 6);
      check_bit(ss, 1'b0, "early retry");
      wait_on(1, 1'b1, 10);
      finish_start();
      $display("test short done");
   endtask
   task automatic t_hot();
      peak = 1'b1;
      wait_on(2, 1'b1, 8);
      hot = 1'b1;
      wait_on(0, 1'b0, 6);
      check_bit(pin, 1'b1, "pin low");
      peak = 1'b0;
      tick(RTY + 20);
      check_bit(ss, 1'b0, "retry while hot");
      hot = 1'b0;
      wait_on(1, 1'b1, RTY + 10);
      finish_start();
      $display("test hot done");
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      {reset, enable, done, ov, uv, peak, shrt, hot} = 8'hFF;
      {enable, done, ov, uv, peak, shrt, hot} = 7'h00;
      sel = 4'h0;
      num_errors = 0;
      total_checks = 0;
      cycles = 0;
      tick(3);
      reset = 1'b0;
      check_bit(pin, 1'b1, "pin low after reset");
      check_rate(rate, RATES[9:0]);
      t_rate();
      t_start();
      t_volt(0);
      t_volt(1);
      t_limit();
      t_short();
      t_hot();
      finish_test();
   end
endmodule // buck_fault_supervisor_tb_top

// ==== flag_sync.sv ====
// Three-stage flag synchroniser with agreement check
`timescale 1ns/1ps
module flag_sync (
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RESET,
   // Flag
   input  wire logic flag_in,
   output logic      flag_out
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s1       <= 1'b0;
         s2       <= 1'b0;
         s3       <= 1'b0;
         flag_out <= 1'b0;
      end else begin
         s1 <= flag_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            flag_out <= s3;
         end
      end
   end
endmodule // flag_sync

// ==== host_monitor.sv ====
// Host side model of the open-drain power-good line
`timescale 1ns/1ps
module host_monitor (
   // Pin drive from the supervisor
   input  wire logic drive_level,
   input  wire logic drive_enable,
   // Line level seen by the host
   output logic      supply_ok_n
);
   // ***************************************
   // Pull-up resistor: released line reads high
   // ***************************************
   assign supply_ok_n = drive_enable ? drive_level : 1'b1;
endmodule // host_monitor
